//--- logic/bidir_port_change_irq.sv
// Operation
// - Direction bit one makes the pin input, zero makes it output.
// - Data reads return pin levels; data writes only load the latch.
// - First port pull-ups all on while the shared control bit is clear.
// - Pull-up forced off on any first-port pin set as output.
// - Every reset leaves the first port pull-ups enabled.
// - Output pins are excluded from the change comparison.
// - Input pins versus latch, mismatches ORed, set the change flag.
// - The change interrupt can wake the device from sleep.
// - A persisting mismatch keeps setting the flag until port rewritten.
// - Change flag value after reset need not be meaningful.
// - Second port is 8-bit bidirectional with same direction and access.
// - Read-modify-write reads pins and writes the whole latch.
//
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "gpio_port_consts.svh"

module bidir_port_change_irq
    import gpio_port_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Register port
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    output logic [7:0] regRdData,
    // First port pins
    input wire logic [7:0] firstPinIn,
    output var pin_drive_s firstPinDrive,
    output logic [7:0] firstPullupOn,
    // Second port pins
    input wire logic [7:0] secondPinIn,
    output var pin_drive_s secondPinDrive,
    // Power and interrupt
    input wire logic sleepActive,
    output logic wakeReq,
    output logic irq
);

    function automatic logic regHit(input logic stb, input logic [3:0] addr, input logic [3:0] ofs);
        return stb && (addr == ofs);
    endfunction

    port_byte_t firstLatch;
    port_byte_t firstDir;
    port_byte_t secondLatch;
    port_byte_t secondDir;
    port_byte_t firstMismatch;
    port_byte_t pullWant;
    logic anyMismatch;
    logic flagClearWr;
    logic pullupEnN_q;
    logic changeFlag_q;
    logic [1:0] intStatus_q;
    logic [1:0] intMask_q;
    logic [1:0] intEvent;
    logic [7:0] rdData_q;
    logic [7:0] pullOn_q;
    logic wake_q;
    logic irq_q;

    assign regRdData = rdData_q;
    assign firstPullupOn = pullOn_q;
    assign wakeReq = wake_q;
    assign irq = irq_q;

    // first port latch, direction and driver
    port_pin_bank uFirst (
        .ref_clk(ref_clk),
        .srst(srst),
        .dataWr(regHit(regWrStb, regAddr, `OFS_FIRST_DATA)),
        .dirWr(regHit(regWrStb, regAddr, `OFS_FIRST_DIR)),
        .wrData(regWrData),
        .latchBits(firstLatch),
        .dirBits(firstDir),
        .drive(firstPinDrive)
    );

    port_pin_bank uSecond (
        .ref_clk(ref_clk),
        .srst(srst),
        .dataWr(regHit(regWrStb, regAddr, `OFS_SECOND_DATA)),
        .dirWr(regHit(regWrStb, regAddr, `OFS_SECOND_DIR)),
        .wrData(regWrData),
        .latchBits(secondLatch),
        .dirBits(secondDir),
        .drive(secondPinDrive)
    );

    // only input pins compared against the latch
    assign firstMismatch = firstDir & (firstPinIn ^ firstLatch);
    assign anyMismatch = |firstMismatch;

    // zero written to the flag bit
    assign flagClearWr = regHit(regWrStb, regAddr, `OFS_PERIPH_FLAG) && !regWrData[`CHANGE_FLAG_BIT];

    // control bit clears on every reset, enabling pull-ups
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            pullupEnN_q <= `PULLUP_N_RESET;
        else if (regHit(regWrStb, regAddr, `OFS_AUX_PORT))
            pullupEnN_q <= regWrData[`PULLUP_N_BIT];
    end

    // per-pin pull-up follows control bit and direction
    localparam port_byte_t PULL_ON_INIT = `PULL_ON_RESET;
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : gPull
            assign pullWant[gi] = !pullupEnN_q && firstDir[gi];
            always_ff @(posedge ref_clk)
            begin
                if (srst)
                    pullOn_q[gi] <= PULL_ON_INIT[gi];
                else
                    pullOn_q[gi] <= pullWant[gi];
            end
        end
    endgenerate

    // set wins over clear; clear only lands with no mismatch
    // reset value is forced only to keep simulation clean
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            changeFlag_q <= 1'b0;
        else if (anyMismatch)
            changeFlag_q <= 1'b1;
        else if (flagClearWr)
            changeFlag_q <= 1'b0;
    end

    // wake request while sleeping and a change is pending
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            wake_q <= 1'b0;
        else
            wake_q <= sleepActive && (anyMismatch || changeFlag_q);
    end

    assign intEvent[`INT_CHANGE_BIT] = anyMismatch;
    assign intEvent[`INT_WAKE_BIT] = sleepActive && anyMismatch;

    // Sticky status, write one to clear; a new event beats the clear
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            intStatus_q <= 2'h0;
        else if (regHit(regWrStb, regAddr, `OFS_INT_STATUS))
            intStatus_q <= (intStatus_q & ~regWrData[1:0]) | intEvent;
        else
            intStatus_q <= intStatus_q | intEvent;
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
            intMask_q <= `INT_MASK_RESET;
        else if (regHit(regWrStb, regAddr, `OFS_INT_MASK))
            intMask_q <= regWrData[1:0];
    end

    // Registered so the output comes from a flop; one cycle behind status
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            irq_q <= 1'b0;
        else
            irq_q <= |(intStatus_q & intMask_q);
    end

    // data reads return pin levels, never the latch
    always_ff @(posedge ref_clk)
    begin
        if (srst || !regRdStb)
            rdData_q <= `READ_IDLE;
        else
        begin
            case (regAddr)
                `OFS_FIRST_DATA: rdData_q <= firstPinIn;
                `OFS_FIRST_DIR: rdData_q <= firstDir;
                `OFS_SECOND_DATA: rdData_q <= secondPinIn;
                `OFS_SECOND_DIR: rdData_q <= secondDir;
                `OFS_AUX_PORT: rdData_q <= {pullupEnN_q, 7'h00};
                `OFS_PERIPH_FLAG: rdData_q <= {changeFlag_q, 7'h00};
                `OFS_INT_STATUS: rdData_q <= {6'h00, intStatus_q};
                `OFS_INT_MASK: rdData_q <= {6'h00, intMask_q};
                default: rdData_q <= `READ_IDLE;
            endcase
        end
    end

    default clocking cbDef @(posedge ref_clk);
    endclocking
    default disable iff (srst);

    a_dir_enable_map: assert property (
        (firstPinDrive.enable == ~firstDir) && (secondPinDrive.enable == ~secondDir))
        else $error("pin enable does not follow direction");

    a_latch_on_write: assert property (
        regHit(regWrStb, regAddr, `OFS_FIRST_DATA) |=> firstPinDrive.level == $past(regWrData))
        else $error("first port latch missed a write");

    a_latch_holds: assert property (
        !regHit(regWrStb, regAddr, `OFS_FIRST_DATA) |=> $stable(firstPinDrive.level))
        else $error("first port latch changed without a write");

    a_read_pins: assert property (
        regHit(regRdStb, regAddr, `OFS_FIRST_DATA) |=> regRdData == $past(firstPinIn))
        else $error("first port read did not return pin levels");

    a_read_second: assert property (
        regHit(regRdStb, regAddr, `OFS_SECOND_DATA) |=> regRdData == $past(secondPinIn))
        else $error("second port read did not return pin levels");

    a_pull_follow: assert property (
        !$past(srst) |-> firstPullupOn == $past(pullWant))
        else $error("pull-up enables do not follow control bit");

    a_pull_output_off: assert property (
        !$past(srst) |-> (firstPullupOn & ~$past(firstDir)) == 8'h00)
        else $error("pull-up left on an output pin");

    a_pull_reset_on: assert property (@(posedge ref_clk) disable iff (1'b0)
        srst |=> (firstPullupOn == 8'hFF) && !pullupEnN_q)
        else $error("pull-ups not enabled after reset");

    a_flag_cause: assert property (
        $rose(changeFlag_q) |-> $past(anyMismatch))
        else $error("change flag rose without an input mismatch");

    a_flag_set: assert property (
        !srst && anyMismatch |=> changeFlag_q)
        else $error("mismatch did not set change flag");

    a_flag_persist: assert property (
        anyMismatch ##1 (anyMismatch && flagClearWr) |=> changeFlag_q)
        else $error("clear won over a persisting mismatch");

    a_flag_sticky: assert property (
        changeFlag_q && !flagClearWr |=> changeFlag_q)
        else $error("change flag dropped without a clear write");

    a_wake_req: assert property (
        !srst && sleepActive && anyMismatch |=> wakeReq ##1 (wakeReq || !sleepActive))
        else $error("no wake request on change during sleep");

    a_second_write: assert property (
        !srst && regHit(regWrStb, regAddr, `OFS_SECOND_DATA) |=> secondPinDrive.level == $past(regWrData))
        else $error("second port latch missed a write");

    a_second_hold: assert property (
        !regHit(regWrStb, regAddr, `OFS_SECOND_DATA) |=> $stable(secondPinDrive.level))
        else $error("second port latch changed without a write");

    a_dir_write: assert property (
        !srst && regHit(regWrStb, regAddr, `OFS_FIRST_DIR) |=> firstDir == $past(regWrData))
        else $error("first port direction missed a write");

    a_dir_second: assert property (
        !srst && regHit(regWrStb, regAddr, `OFS_SECOND_DIR) |=> secondDir == $past(regWrData))
        else $error("second port direction missed a write");

    a_dir_holds: assert property (
        !regHit(regWrStb, regAddr, `OFS_FIRST_DIR) |=> $stable(firstDir))
        else $error("first port direction changed without a write");

    a_read_dir: assert property (
        !srst && regHit(regRdStb, regAddr, `OFS_FIRST_DIR) |=> regRdData == $past(firstDir))
        else $error("first direction read returned a wrong value");

    a_read_dir_second: assert property (
        !srst && regHit(regRdStb, regAddr, `OFS_SECOND_DIR) |=> regRdData == $past(secondDir))
        else $error("second direction read returned a wrong value");

    a_read_idle: assert property (
        !regRdStb |=> regRdData == `READ_IDLE)
        else $error("read data did not return to idle");

    a_read_flag: assert property (
        !srst && regHit(regRdStb, regAddr, `OFS_PERIPH_FLAG) |=> regRdData == {$past(changeFlag_q), 7'h00})
        else $error("flag register read returned a wrong value");

    a_read_aux: assert property (
        !srst && regHit(regRdStb, regAddr, `OFS_AUX_PORT) |=> regRdData == {$past(pullupEnN_q), 7'h00})
        else $error("pull-up control read returned a wrong value");

    a_read_unmapped: assert property (
        !srst && regRdStb && (regAddr > `OFS_INT_MASK) |=> regRdData == `READ_IDLE)
        else $error("unmapped read returned data");

    a_flag_clear: assert property (
        !srst && changeFlag_q && flagClearWr && !anyMismatch |=> !changeFlag_q)
        else $error("change flag not cleared by a zero write");

    a_pull_ctrl_write: assert property (
        !srst && regHit(regWrStb, regAddr, `OFS_AUX_PORT) |=> pullupEnN_q == $past(regWrData[`PULLUP_N_BIT]))
        else $error("pull-up control bit missed a write");

    a_pull_all_off: assert property (
        !srst && pullupEnN_q |=> firstPullupOn == 8'h00)
        else $error("pull-up left on while control bit set");

    a_status_change: assert property (
        !srst && anyMismatch |=> intStatus_q[`INT_CHANGE_BIT])
        else $error("mismatch did not set change status");

    a_status_wake: assert property (
        !srst && sleepActive && anyMismatch |=> intStatus_q[`INT_WAKE_BIT])
        else $error("mismatch in sleep did not set wake status");

    a_status_clear: assert property (
        !srst && regHit(regWrStb, regAddr, `OFS_INT_STATUS) && regWrData[`INT_CHANGE_BIT] && !anyMismatch
            |=> !intStatus_q[`INT_CHANGE_BIT])
        else $error("change status not cleared by a one write");

    a_irq_level: assert property (
        !srst |=> irq == |($past(intStatus_q) & $past(intMask_q)))
        else $error("interrupt does not follow masked status");

    a_irq_masked: assert property (
        !srst && (intMask_q == 2'h0) |=> !irq)
        else $error("interrupt raised with all sources masked");

    a_wake_idle: assert property (
        !sleepActive |=> !wakeReq)
        else $error("wake request while awake");

endmodule // bidir_port_change_irq

`default_nettype wire

//--- logic/gpio_port_consts.svh
`ifndef GPIO_PORT_CONSTS_SVH
`define GPIO_PORT_CONSTS_SVH

// Register offsets on the plain register port
`define OFS_FIRST_DATA 4'h0
`define OFS_FIRST_DIR 4'h1
`define OFS_SECOND_DATA 4'h2
`define OFS_SECOND_DIR 4'h3
`define OFS_AUX_PORT 4'h4
`define OFS_PERIPH_FLAG 4'h5
`define OFS_INT_STATUS 4'h6
`define OFS_INT_MASK 4'h7

// Field positions
`define PULLUP_N_BIT 7
`define CHANGE_FLAG_BIT 7
`define INT_CHANGE_BIT 0
`define INT_WAKE_BIT 1

// Reset values
`define DIR_RESET 8'hFF
`define LATCH_RESET 8'h00
`define PULLUP_N_RESET 1'b0
`define PULL_ON_RESET 8'hFF
`define INT_MASK_RESET 2'h0
`define READ_IDLE 8'h00

`endif

//--- logic/gpio_port_pkg.sv
package gpio_port_pkg;

    typedef logic [7:0] port_byte_t;

    // One port's pin driver state
    typedef struct packed {
        logic [7:0] level;
        logic [7:0] enable;
    } pin_drive_s;

endpackage

//--- logic/port_pin_bank.sv
`timescale 1ns/10ps
`default_nettype none
`include "gpio_port_consts.svh"

module port_pin_bank
    import gpio_port_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Register writes
    input wire logic dataWr,
    input wire logic dirWr,
    input wire logic [7:0] wrData,
    // State seen by the owner
    output port_byte_t latchBits,
    output port_byte_t dirBits,
    output var pin_drive_s drive
);

    port_byte_t latch_q;
    port_byte_t dir_q;
    port_byte_t oe_q;

    assign latchBits = latch_q;
    assign dirBits = dir_q;
    assign drive.level = latch_q;
    assign drive.enable = oe_q;

    // Latch loads on every data write, whatever the pin direction
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            latch_q <= `LATCH_RESET;
        else if (dataWr)
            latch_q <= wrData;
    end

    // Separate enable flop so the pin driver comes straight from a register
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            dir_q <= `DIR_RESET;
            oe_q <= ~`DIR_RESET;
        end
        else if (dirWr)
        begin
            dir_q <= wrData;
            oe_q <= ~wrData;
        end
    end

endmodule // port_pin_bank

`default_nettype wire

//--- tb/pin_keypad_model.sv
`timescale 1ns/10ps
`default_nettype none
module pin_keypad_model
    import gpio_port_pkg::*;
(
    // Clock
    input wire logic ref_clk,
    // Device side
    input wire pin_drive_s firstDrive,
    input wire pin_drive_s secondDrive,
    input wire logic [7:0] firstPullupOn,
    output logic [7:0] firstPinIn,
    output logic [7:0] secondPinIn,
    // Bench commands
    input wire logic [7:0] keyDown,
    input wire logic [7:0] secondExt
);
    logic floatQ = 1'b0;
    always_ff @(posedge ref_clk)
    begin
        floatQ <= ~floatQ;
    end
    // pin resolution
    // Floating input wanders so a missing pull-up shows
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            firstPinIn[i] = firstDrive.enable[i] ? firstDrive.level[i] :
                keyDown[i] ? 1'b0 : firstPullupOn[i] ? 1'b1 : floatQ;
            secondPinIn[i] = secondDrive.enable[i] ? secondDrive.level[i] : secondExt[i];
        end
    end
endmodule // pin_keypad_model
`default_nettype wire

//--- tb/test_bidir_port_change_irq.sv
`timescale 1ns/10ps
`default_nettype none
`include "gpio_port_consts.svh"
module test_bidir_port_change_irq;
    import gpio_port_pkg::*;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic [3:0] regAddr = 4'h0;
    logic [7:0] regWrData = 8'h00;
    logic regWrStb = 1'b0;
    logic regRdStb = 1'b0;
    logic sleepActive = 1'b0;
    logic [7:0] keyDown = 8'h00;
    logic [7:0] secondExt = 8'h00;
    logic [7:0] regRdData, firstPinIn, secondPinIn, firstPullupOn, rdVal;
    pin_drive_s firstPinDrive, secondPinDrive;
    logic wakeReq, irq;
    int errorCnt = 0;
    int nCompared = 0;
    always #20 ref_clk = ~ref_clk;
    bidir_port_change_irq dut (.ref_clk(ref_clk), .srst(srst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
        .regRdData(regRdData), .firstPinIn(firstPinIn), .firstPinDrive(firstPinDrive),
        .firstPullupOn(firstPullupOn), .secondPinIn(secondPinIn),
        .secondPinDrive(secondPinDrive), .sleepActive(sleepActive), .wakeReq(wakeReq), .irq(irq));
    pin_keypad_model pins (.ref_clk(ref_clk), .firstDrive(firstPinDrive),
        .secondDrive(secondPinDrive), .firstPullupOn(firstPullupOn), .firstPinIn(firstPinIn),
        .secondPinIn(secondPinIn), .keyDown(keyDown), .secondExt(secondExt));
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        nCompared++;
        if (got !== exp)
        begin
            errorCnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'b1;
        @(posedge ref_clk);
        regWrStb <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge ref_clk);
        regAddr <= a;
        regRdStb <= 1'b1;
        @(posedge ref_clk);
        regRdStb <= 1'b0;
        #1;
        rdVal = regRdData;
    endtask
    task automatic rdChk(input logic [3:0] a, input logic [7:0] exp);
        rd(a);
        chk("register read", exp, rdVal);
    endtask
    // Rewrite the port, then clear flag and status
    task automatic service;
        rd(`OFS_FIRST_DATA);
        wr(`OFS_FIRST_DATA, rdVal);
        wr(`OFS_PERIPH_FLAG, 8'h00);
        wr(`OFS_INT_STATUS, 8'h03);
        step(2);
    endtask
    task automatic t_reset;
        rdChk(`OFS_FIRST_DIR, 8'hFF);
        rdChk(`OFS_SECOND_DIR, 8'hFF);
        chk("pull-ups", 8'hFF, firstPullupOn);
        chk("drive enable", 8'h00, firstPinDrive.enable);
        rdChk(`OFS_FIRST_DATA, 8'hFF);
        chk("irq", 8'h00, {7'h00, irq});
    endtask
    task automatic t_drive;
        wr(`OFS_FIRST_DATA, 8'hAF);
        wr(`OFS_FIRST_DIR, 8'h0F);
        step(2);
        chk("drive enable", 8'hF0, firstPinDrive.enable);
        chk("drive level", 8'hAF, firstPinDrive.level);
        chk("pull-ups", 8'h0F, firstPullupOn);
        @(posedge ref_clk);
        keyDown <= 8'h01;
        rdChk(`OFS_FIRST_DATA, 8'hAE);
        chk("latch kept", 8'hAF, firstPinDrive.level);
        keyDown <= 8'h00;
        wr(`OFS_AUX_PORT, 8'h80);
        step(2);
        chk("pull-ups", 8'h00, firstPullupOn);
        wr(`OFS_AUX_PORT, 8'h00);
        step(2);
        chk("pull-ups", 8'h0F, firstPullupOn);
    endtask
    task automatic t_change;
        wr(`OFS_INT_MASK, 8'h01);
        service();
        chk("irq", 8'h00, {7'h00, irq});
        @(posedge ref_clk);
        keyDown <= 8'h04;
        step(3);
        chk("irq", 8'h01, {7'h00, irq});
        rdChk(`OFS_PERIPH_FLAG, 8'h80);
        rdChk(`OFS_INT_STATUS, 8'h01);
        wr(`OFS_PERIPH_FLAG, 8'h00);
        rdChk(`OFS_PERIPH_FLAG, 8'h80);
        service();
        chk("irq", 8'h00, {7'h00, irq});
        rdChk(`OFS_PERIPH_FLAG, 8'h00);
        wr(`OFS_INT_MASK, 8'h00);
        keyDown <= 8'h00;
        step(3);
        chk("irq masked", 8'h00, {7'h00, irq});
        rdChk(`OFS_INT_STATUS, 8'h01);
        wr(`OFS_INT_MASK, 8'h01);
        step(2);
        chk("irq", 8'h01, {7'h00, irq});
        service();
    endtask
    task automatic t_wake;
        @(posedge ref_clk);
        sleepActive <= 1'b1;
        keyDown <= 8'h02;
        step(3);
        chk("wake", 8'h01, {7'h00, wakeReq});
        rd(`OFS_INT_STATUS);
        chk("wake status", 8'h02, rdVal & 8'h02);
        @(posedge ref_clk);
        sleepActive <= 1'b0;
        keyDown <= 8'h00;
        service();
        chk("wake", 8'h00, {7'h00, wakeReq});
    endtask
    task automatic t_second;
        secondExt <= 8'h3C;
        wr(`OFS_SECOND_DATA, 8'h5A);
        wr(`OFS_SECOND_DIR, 8'h0F);
        step(2);
        chk("second enable", 8'hF0, secondPinDrive.enable);
        chk("second level", 8'h5A, secondPinDrive.level);
        rdChk(`OFS_SECOND_DATA, 8'h5C);
        wr(`OFS_SECOND_DATA, rdVal | 8'h01);
        step(2);
        chk("second level", 8'h5D, secondPinDrive.level);
        wr(4'hE, 8'h55);
        rdChk(4'hE, 8'h00);
        rdChk(`OFS_SECOND_DIR, 8'h0F);
    endtask
    // Reset in mid-run with pull-ups switched off beforehand
    task automatic t_rereset;
        wr(`OFS_AUX_PORT, 8'h80);
        step(2);
        chk("pull-ups", 8'h00, firstPullupOn);
        @(posedge ref_clk);
        srst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        srst <= 1'b0;
        step(2);
        chk("pull-ups", 8'hFF, firstPullupOn);
        chk("drive enable", 8'h00, firstPinDrive.enable);
        rdChk(`OFS_AUX_PORT, 8'h00);
        step(1);
        chk("read idle", 8'h00, regRdData);
    endtask
    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", nCompared, errorCnt);
        if (errorCnt == 0 && nCompared > 0)
        begin
            $display("SIMULATION PASSED");
        end
        else
        begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial
    begin
        repeat (10) @(posedge ref_clk);
        srst <= 1'b0;
        t_reset();
        t_drive();
        t_change();
        t_wake();
        t_second();
        t_rereset();
        tally_and_finish();
    end
    // Whole run needs well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge ref_clk);
        errorCnt++;
        tally_and_finish();
    end
endmodule // test_bidir_port_change_irq
`default_nettype wire
